//--- auxclk_far_model.sv
// Far-side model: two reference clocks and a sysref source for the aux clock selector.
// Assumes the bench drives sr_pulse and sr_per just after rising edges of ref_clk.
module auxclk_far_model
(
   input  wire logic ref_clk,
   input  wire logic rst_n,
   input  wire logic sr_pulse,
   input  wire logic sr_per,
   output logic      diff_clk_in,
   output logic      single_ended_clk_in,
   output logic      sysref_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] ck_q;
   logic [5:0] per_q;
   logic [3:0] pls_q;
   // ==========================================================
   // Sources
   always @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         ck_q                <= 8'h00;
         per_q               <= 6'h00;
         pls_q               <= 4'h0;
         diff_clk_in         <= 1'b0;
         single_ended_clk_in <= 1'b0;
         sysref_in           <= 1'b0;
      end
      else
      begin
         ck_q <= ck_q + 8'h01;
         // Different rates so the chosen source shows at the outputs
         diff_clk_in <= ck_q[2];
         single_ended_clk_in <= ck_q[3];
         per_q <= sr_per ? per_q + 6'h01 : 6'h00;
         pls_q <= sr_pulse ? 4'h8 : ((pls_q != 4'h0) ? pls_q - 4'h1 : 4'h0);
         // Period of 64 reference cycles, low for 48 of them between pulses
         sysref_in <= (pls_q != 4'h0) || (sr_per && per_q[5:4] == 2'h0);
      end
   end
endmodule

//--- auxclk_pkg.sv
// Constants, codes and decode helpers for the auxiliary clock output selector.
// Assumes a single 40 MHz register clock and a 32-bit classic Wishbone register port.
package auxclk_pkg;

   // ==========================================================
   // Register map
   localparam int unsigned AW          = 8;
   localparam logic [7:0]  ADR_CTRL    = 8'h00;
   localparam logic [7:0]  ADR_STAT    = 8'h04;
   localparam logic [7:0]  ADR_POS     = 8'h08;
   localparam logic [7:0]  ADR_CNT     = 8'h0C;

   // ==========================================================
   // Control fields
   localparam int unsigned CTRL_OVR    = 0;
   localparam int unsigned CTRL_OREN   = 1;
   localparam int unsigned CTRL_MC     = 4;
   localparam int unsigned CTRL_MD     = 8;
   localparam int unsigned CTRL_SEL    = 16;
   localparam logic [31:0] CTRL_RST    = 32'h0000_0000;
   localparam logic [31:0] CTRL_WMASK  = 32'h000F_0333;

   // ==========================================================
   // Status fields
   localparam int unsigned STAT_FC     = 0;
   localparam int unsigned STAT_FD     = 4;
   localparam int unsigned STAT_PD     = 8;
   localparam int unsigned STAT_RSEL   = 9;
   localparam int unsigned STAT_PINS   = 10;

   // ==========================================================
   // Sysref window
   localparam int unsigned NPOS        = 24;
   localparam int unsigned PH_W        = 5;
   localparam int unsigned SEL_W       = 4;
   localparam int unsigned CNT_W       = 16;
   localparam logic [23:0] POS_FIXED   = 24'h80_0001;

   // ==========================================================
   // Mode codes, shared by pins and mode fields
   localparam logic [1:0]  MODE_OFF    = 2'h0;
   localparam logic [1:0]  MODE_REF    = 2'h1;
   localparam logic [1:0]  MODE_DIV2   = 2'h2;
   localparam logic [1:0]  MODE_DIV4   = 2'h3;

   typedef enum logic [2:0] {FN_OFF, FN_OVR, FN_REF, FN_DIV2, FN_DIV4} auxclk_fn_e;

   // Any clock code outranks over-range
   function automatic auxclk_fn_e auxclk_code2fn(input logic [1:0] code, input logic oren);
      auxclk_fn_e f;
      f = FN_OFF;
      case (code)
         MODE_REF:  f = FN_REF;
         MODE_DIV2: f = FN_DIV2;
         MODE_DIV4: f = FN_DIV4;
         default:   f = oren ? FN_OVR : FN_OFF;
      endcase
      return f;
   endfunction

   function automatic logic auxclk_fn_level(input auxclk_fn_e f, input logic r,
                                            input logic d2, input logic d4, input logic ov);
      logic l;
      l = 1'b0;
      case (f)
         FN_REF:  l = r;
         FN_DIV2: l = d2;
         FN_DIV4: l = d4;
         FN_OVR:  l = ov;
         default: l = 1'b0;
      endcase
      return l;
   endfunction

endpackage

//--- auxclk_ref_div.sv
// Reference input selection and /2, /4 division of the sampled reference.
// Assumes the reference pins are asynchronous and well below a quarter of ref_clk.
module auxclk_ref_div
   import auxclk_pkg::*;
(
   input  wire logic       ref_clk,
   input  wire logic       rst_n,
   input  wire logic       clk_en,
   input  wire logic       diff_clk_in,
   input  wire logic       single_ended_clk_in,
   input  wire logic       ref_sel_se,
   auxclk_ref_if.src       refo
);

   logic       diff_s1_q;
   logic       diff_s2_q;
   logic       se_s1_q;
   logic       se_s2_q;
   logic       lvl_q;
   logic       rise_q;
   logic [1:0] cnt_q;
   wire  logic sel_lvl;
   wire  logic sel_rise;

   assign sel_lvl  = ref_sel_se ? se_s2_q : diff_s2_q;
   assign sel_rise = sel_lvl & ~lvl_q;

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         diff_s1_q <= 1'b0;
         diff_s2_q <= 1'b0;
         se_s1_q   <= 1'b0;
         se_s2_q   <= 1'b0;
         lvl_q     <= 1'b0;
         rise_q    <= 1'b0;
         cnt_q     <= 2'h0;
      end
      else if (clk_en)
      begin
         diff_s1_q <= diff_clk_in;
         diff_s2_q <= diff_s1_q;
         se_s1_q   <= single_ended_clk_in;
         se_s2_q   <= se_s1_q;
         lvl_q     <= sel_lvl;
         rise_q    <= sel_rise;
         if (sel_rise)
            cnt_q <= cnt_q + 2'h1;
      end
   end

   assign refo.lvl  = lvl_q;
   assign refo.rise = rise_q;
   assign refo.div2 = cnt_q[0];
   assign refo.div4 = cnt_q[1];

   // ==========================================================
   // Checks
   property p_ref_select;
      @(posedge ref_clk) disable iff (!rst_n)
      (clk_en && ref_sel_se) |=> (lvl_q == $past(se_s2_q));
   endproperty
   a_ref_select: assert property (p_ref_select) else $error("reference not from selected input");

endmodule

//--- auxclk_ref_if.sv
// Selected reference clock, sampled, with its edge and divided copies.
// Driven by the divider, read by the sysref window and the output mux.
interface auxclk_ref_if;
   logic lvl;
   logic rise;
   logic div2;
   logic div4;

   modport src (output lvl, output rise, output div2, output div4);
   modport snk (input lvl, input rise, input div2, input div4);
endinterface

//--- auxclk_sel_top.sv
// Auxiliary CMOS clock output selector with sysref windowing and Wishbone registers.
// Assumes all pins are asynchronous to ref_clk; the reference runs well below ref_clk/4.
module auxclk_sel_top
   import auxclk_pkg::*;
(
   input  wire logic          ref_clk,
   input  wire logic          rst_n,
   input  wire logic          clk_en,
   input  wire logic          wb_cyc_i,
   input  wire logic          wb_stb_i,
   input  wire logic          wb_we_i,
   input  wire logic [AW-1:0] wb_adr_i,
   input  wire logic [3:0]    wb_sel_i,
   input  wire logic [31:0]   wb_dat_i,
   output logic      [31:0]   wb_dat_o,
   output logic               wb_ack_o,
   input  wire logic          power_down_pin,
   input  wire logic [1:0]    clk_out_cfg_pins,
   input  wire logic          ref_input_select,
   input  wire logic          diff_clk_in,
   input  wire logic          single_ended_clk_in,
   input  wire logic          overrange_c_in,
   input  wire logic          overrange_d_in,
   input  wire logic          sysref_in,
   output logic               aux_out_c,
   output logic               aux_out_d,
   output logic               sysref_capt
);

   // ==========================================================
   // Pin synchronisers
   logic [1:0] pd_sy_q;
   logic [1:0] rsel_sy_q;
   logic [1:0] ovc_sy_q;
   logic [1:0] ovd_sy_q;
   logic [1:0] sr_sy_q;
   logic [1:0] pins_s1_q;
   logic [1:0] pins_s2_q;

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         pd_sy_q   <= 2'h0;
         rsel_sy_q <= 2'h0;
         ovc_sy_q  <= 2'h0;
         ovd_sy_q  <= 2'h0;
         sr_sy_q   <= 2'h0;
         pins_s1_q <= 2'h0;
         pins_s2_q <= 2'h0;
      end
      else if (clk_en)
      begin
         pd_sy_q   <= {pd_sy_q[0], power_down_pin};
         rsel_sy_q <= {rsel_sy_q[0], ref_input_select};
         ovc_sy_q  <= {ovc_sy_q[0], overrange_c_in};
         ovd_sy_q  <= {ovd_sy_q[0], overrange_d_in};
         sr_sy_q   <= {sr_sy_q[0], sysref_in};
         pins_s1_q <= clk_out_cfg_pins;
         pins_s2_q <= pins_s1_q;
      end
   end

   wire logic       pd_s   = pd_sy_q[1];
   wire logic       rsel_s = rsel_sy_q[1];
   wire logic       ovc_s  = ovc_sy_q[1];
   wire logic       ovd_s  = ovd_sy_q[1];
   wire logic       sr_s   = sr_sy_q[1];
   wire logic [1:0] pins_s = pins_s2_q;

   // ==========================================================
   // Reference path and sysref window
   auxclk_ref_if refb ();

   logic [NPOS-1:0] pos_w;
   logic            capt_w;
   logic [31:0]     ctrl_q;
   logic            pos_clr;

   auxclk_ref_div u_div (
      .ref_clk             (ref_clk),
      .rst_n               (rst_n),
      .clk_en              (clk_en),
      .diff_clk_in         (diff_clk_in),
      .single_ended_clk_in (single_ended_clk_in),
      .ref_sel_se          (rsel_s),
      .refo                (refb)
   );

   auxclk_sysref_win u_win (
      .ref_clk  (ref_clk),
      .rst_n    (rst_n),
      .clk_en   (clk_en),
      .refi     (refb),
      .sysref_s (sr_s),
      .sel      (ctrl_q[CTRL_SEL +: SEL_W]),
      .pos_clr  (pos_clr),
      .pos_o    (pos_w),
      .capt_o   (capt_w)
   );

   // ==========================================================
   // Output function selection
   wire logic       pin_override_en  = ctrl_q[CTRL_OVR];
   wire logic       overrange_out_en = ctrl_q[CTRL_OREN];
   wire logic [1:0] ref_div_sel_c    = ctrl_q[CTRL_MC +: 2];
   wire logic [1:0] ref_div_sel_d    = ctrl_q[CTRL_MD +: 2];

   wire logic [1:0] code_c  = pin_override_en ? ref_div_sel_c : pins_s;
   // Pins only switch D on or off; no divider choice reaches D from them
   wire logic [1:0] pin_d   = (pins_s != MODE_OFF) ? MODE_REF : MODE_OFF;
   wire logic [1:0] code_dr = pin_override_en ? ref_div_sel_d : pin_d;
   wire logic [1:0] code_d  = (code_c == MODE_OFF) ? MODE_OFF : code_dr;

   wire auxclk_fn_e fn_c = auxclk_code2fn(code_c, overrange_out_en);
   wire auxclk_fn_e fn_d = auxclk_code2fn(code_d, overrange_out_en);

   wire logic lvl_c = auxclk_fn_level(fn_c, refb.lvl, refb.div2, refb.div4, ovc_s);
   wire logic lvl_d = auxclk_fn_level(fn_d, refb.lvl, refb.div2, refb.div4, ovd_s);

   logic            aux_c_q;
   logic            aux_d_q;
   logic            capt_q;
   logic [CNT_W-1:0] cnt_q;

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         aux_c_q <= 1'b0;
         aux_d_q <= 1'b0;
         capt_q  <= 1'b0;
         cnt_q   <= '0;
      end
      else if (clk_en)
      begin
         aux_c_q <= lvl_c & ~pd_s;
         aux_d_q <= lvl_d & ~pd_s;
         capt_q  <= capt_w;
         if (capt_w)
            cnt_q <= cnt_q + CNT_W'(1);
      end
   end

   assign aux_out_c   = aux_c_q;
   assign aux_out_d   = aux_d_q;
   assign sysref_capt = capt_q;

   // ==========================================================
   // Wishbone slave, one wait state, unmapped reads return zero
   logic        ack_q;
   logic [31:0] rdat_q;

   wire logic        req      = wb_cyc_i & wb_stb_i & ~ack_q;
   wire logic        wr_ctrl  = req & wb_we_i & (wb_adr_i == ADR_CTRL);
   assign            pos_clr  = clk_en & req & wb_we_i & (wb_adr_i == ADR_POS);
   wire logic [31:0] lane     = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                                 {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   wire logic [31:0] wmask    = lane & CTRL_WMASK;
   wire logic [31:0] ctrl_d   = (ctrl_q & ~wmask) | (wb_dat_i & wmask);

   wire logic [31:0] stat_w   = (32'(fn_c) << STAT_FC) | (32'(fn_d) << STAT_FD)
                              | (32'(pd_s) << STAT_PD) | (32'(rsel_s) << STAT_RSEL)
                              | (32'(pins_s) << STAT_PINS);

   wire logic [31:0] rd_mux   = (wb_adr_i == ADR_CTRL) ? ctrl_q :
                                (wb_adr_i == ADR_STAT) ? stat_w :
                                (wb_adr_i == ADR_POS)  ? 32'(pos_w) :
                                (wb_adr_i == ADR_CNT)  ? 32'(cnt_q) : 32'h0000_0000;

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         ack_q  <= 1'b0;
         rdat_q <= 32'h0000_0000;
         ctrl_q <= CTRL_RST;
      end
      else if (clk_en)
      begin
         ack_q  <= req;
         rdat_q <= req ? rd_mux : 32'h0000_0000;
         if (wr_ctrl)
            ctrl_q <= ctrl_d;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdat_q;

   // ==========================================================
   // Checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   sequence s_live;
      clk_en && !pd_s;
   endsequence

   property p_pd_off;
      (clk_en && pd_s) |=> (!aux_c_q && !aux_d_q);
   endproperty
   a_pd_off: assert property (p_pd_off) else $error("output active in power-down");

   property p_c_pins_ref;
      (s_live and !pin_override_en && pins_s == MODE_REF) |=> aux_c_q == $past(refb.lvl);
   endproperty
   a_c_pins_ref: assert property (p_c_pins_ref) else $error("C not reference from pins");

   property p_c_pins_div4;
      (s_live and !pin_override_en && pins_s == MODE_DIV4) |=> aux_c_q == $past(refb.div4);
   endproperty
   a_c_pins_div4: assert property (p_c_pins_div4) else $error("C not ref/4 from pins");

   property p_c_mode_div2;
      (s_live and pin_override_en && ref_div_sel_c == MODE_DIV2)
         |=> aux_c_q == $past(refb.div2);
   endproperty
   a_c_mode_div2: assert property (p_c_mode_div2) else $error("C ignores mode field");

   property p_c_ovr;
      (s_live and code_c == MODE_OFF && overrange_out_en) |=> aux_c_q == $past(ovc_s);
   endproperty
   a_c_ovr: assert property (p_c_ovr) else $error("C over-range not shown");

   property p_d_pins_ref;
      (s_live and !pin_override_en && pins_s != MODE_OFF) |=> aux_d_q == $past(refb.lvl);
   endproperty
   a_d_pins_ref: assert property (p_d_pins_ref) else $error("D not reference from pins");

   property p_d_mode_div4;
      (s_live and pin_override_en && ref_div_sel_c != MODE_OFF && ref_div_sel_d == MODE_DIV4)
         |=> aux_d_q == $past(refb.div4);
   endproperty
   a_d_mode_div4: assert property (p_d_mode_div4) else $error("D ignores mode field");

   property p_d_needs_c;
      (s_live and pin_override_en && ref_div_sel_c == MODE_OFF)
         |=> aux_d_q == $past(overrange_out_en && ovd_s);
   endproperty
   a_d_needs_c: assert property (p_d_needs_c) else $error("D clock without C clock");

   property p_clock_beats_ovr;
      (code_c != MODE_OFF) |-> (fn_c != FN_OVR);
   endproperty
   a_clock_beats_ovr: assert property (p_clock_beats_ovr) else $error("over-range outranks clock");

   property p_capt_count;
      (clk_en && capt_w) |=> (capt_q && cnt_q == $past(cnt_q) + CNT_W'(1));
   endproperty
   a_capt_count: assert property (p_capt_count) else $error("capture not counted");

   property p_c_pins_div2;
      (s_live and !pin_override_en && pins_s == MODE_DIV2) |=> aux_c_q == $past(refb.div2);
   endproperty
   a_c_pins_div2: assert property (p_c_pins_div2) else $error("C not ref/2 from pins");

   property p_c_mode_ref;
      (s_live and pin_override_en && ref_div_sel_c == MODE_REF)
         |=> aux_c_q == $past(refb.lvl);
   endproperty
   a_c_mode_ref: assert property (p_c_mode_ref) else $error("C mode ref lost");

   property p_c_mode_div4;
      (s_live and pin_override_en && ref_div_sel_c == MODE_DIV4)
         |=> aux_c_q == $past(refb.div4);
   endproperty
   a_c_mode_div4: assert property (p_c_mode_div4) else $error("C mode ref/4 lost");

   // Pins 00 leave D to over-range, whatever the mode fields hold
   property p_d_pins_ovr;
      (s_live and !pin_override_en && pins_s == MODE_OFF)
         |=> aux_d_q == $past(overrange_out_en && ovd_s);
   endproperty
   a_d_pins_ovr: assert property (p_d_pins_ovr) else $error("D wrong for pins 00");

   property p_d_mode_div2;
      (s_live and pin_override_en && ref_div_sel_c != MODE_OFF && ref_div_sel_d == MODE_DIV2)
         |=> aux_d_q == $past(refb.div2);
   endproperty
   a_d_mode_div2: assert property (p_d_mode_div2) else $error("D mode ref/2 lost");

   // Bus: a take is answered on the next edge, and the answer lasts one cycle
   sequence s_take;
      clk_en && wb_cyc_i && wb_stb_i && !ack_q;
   endsequence

   property p_ack_next;
      s_take |=> ack_q;
   endproperty
   a_ack_next: assert property (p_ack_next) else $error("access not acknowledged");

   property p_ack_drop;
      (clk_en && ack_q) |=> !ack_q;
   endproperty
   a_ack_drop: assert property (p_ack_drop) else $error("ack held too long");

endmodule

//--- auxclk_sel_top_bench.sv
// Self-checking bench for the aux clock output selector.
// Assumes the far-side model file and the design files are compiled first.
module auxclk_sel_top_bench
   import auxclk_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed
   {
      logic ovr; logic oren; logic [1:0] mc; logic [1:0] md;
      logic [1:0] pins; logic [2:0] fc; logic [2:0] fd;
   } auxclk_row_s;
   auxclk_row_s rows [12] = '{'{0,0,0,0,0,0,0}, '{0,1,0,0,0,1,1}, '{0,0,0,0,1,2,2},
      '{0,1,0,0,2,3,2}, '{0,0,0,0,3,4,2}, '{1,0,0,1,3,0,0}, '{1,1,0,3,1,1,1},
      '{1,0,1,1,0,2,2}, '{1,1,2,2,0,3,3}, '{1,0,3,3,2,4,4}, '{1,1,1,0,3,2,1},
      '{1,0,2,0,1,3,0}};
   logic ref_clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, power_down_pin;
   logic clk_en = 1'b1;
   logic [AW-1:0] wb_adr_i;
   logic [3:0]    wb_sel_i;
   logic [31:0]   wb_dat_i, wb_dat_o, q, rc, rd;
   logic [1:0]    clk_out_cfg_pins;
   logic ref_input_select, overrange_c_in, overrange_d_in, sr_pulse, sr_per;
   logic diff_clk_in, single_ended_clk_in, sysref_in, aux_out_c, aux_out_d, sysref_capt;
   int failures = 0;
   int n_tests = 0;
   int n_capt = 0;
   int c0;
   auxclk_sel_top i_dut (.ref_clk, .rst_n, .clk_en, .wb_cyc_i, .wb_stb_i, .wb_we_i,
      .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .power_down_pin,
      .clk_out_cfg_pins, .ref_input_select, .diff_clk_in, .single_ended_clk_in,
      .overrange_c_in, .overrange_d_in, .sysref_in, .aux_out_c, .aux_out_d, .sysref_capt);
   auxclk_far_model i_far (.ref_clk, .rst_n, .sr_pulse, .sr_per, .diff_clk_in,
      .single_ended_clk_in, .sysref_in);
   // ==========================================================
   // Clock, watchdog, helpers
   initial
   begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      failures++;
      close_out();
   end
   always @(posedge ref_clk)
      if (sysref_capt === 1'b1) n_capt <= n_capt + 1;
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e)
      begin
         failures++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk_pin(input string nm, input logic e, input logic g);
      n_tests++;
      if (g !== e)
      begin
         failures++;
         $display("ERROR %s expected %b seen %b", nm, e, g);
      end
   endtask
   // Classic single cycle; only the watchdog ends a missing ack
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] r);
      @(posedge ref_clk);
      wb_cyc_i <= 1'b1; wb_stb_i <= 1'b1; wb_we_i <= w;
      wb_adr_i <= a; wb_dat_i <= d; wb_sel_i <= s;
      do
      begin
         @(posedge ref_clk);
      end
      while (wb_ack_o !== 1'b1);
      r = wb_dat_o;
      wb_cyc_i <= 1'b0; wb_stb_i <= 1'b0;
   endtask
   task automatic cnt_rises();
      logic pc, pd;
      rc = 0; rd = 0; pc = aux_out_c; pd = aux_out_d;
      repeat (128)
      begin
         @(posedge ref_clk);
         if (aux_out_c === 1'b1 && pc === 1'b0) rc++;
         if (aux_out_d === 1'b1 && pd === 1'b0) rd++;
         pc = aux_out_c; pd = aux_out_d;
      end
   endtask
   function automatic logic [31:0] er(input logic [2:0] f);
      return (f == 3'h2) ? 32'h0000_0010 : (f == 3'h3) ? 32'h0000_0008 :
             (f == 3'h4) ? 32'h0000_0004 : 32'h0000_0000;
   endfunction
   task automatic pulse_check(input int k, input int e);
      c0 = n_capt;
      repeat (k) @(posedge ref_clk);
      sr_pulse <= 1'b1;
      @(posedge ref_clk);
      sr_pulse <= 1'b0;
      repeat (40) @(posedge ref_clk);
      chk_reg("capt", e, n_capt - c0);
   endtask
   // ==========================================================
   // Sequence
   initial
   begin
      rst_n = 1'b0; wb_cyc_i = 1'b0; wb_stb_i = 1'b0; wb_we_i = 1'b0; wb_adr_i = '0;
      wb_sel_i = 4'h0; wb_dat_i = 32'h0000_0000; power_down_pin = 1'b0; sr_pulse = 1'b0;
      clk_out_cfg_pins = 2'h0; ref_input_select = 1'b0; sr_per = 1'b0;
      overrange_c_in = 1'b1; overrange_d_in = 1'b1;
      repeat (12) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      wb(0, ADR_CTRL, 0, 4'hF, q); chk_reg("ctrl_rst", CTRL_RST, q);
      wb(0, ADR_POS, 0, 4'hF, q); chk_reg("pos_rst", 32'(POS_FIXED), q);
      wb(0, ADR_CNT, 0, 4'hF, q); chk_reg("cnt_rst", 0, q);
      $display("test reset done");
      foreach (rows[i])
      begin
         clk_out_cfg_pins <= rows[i].pins;
         wb(1, ADR_CTRL, {22'h0, rows[i].md, 2'h0, rows[i].mc, 2'h0, rows[i].oren,
            rows[i].ovr}, 4'hF, q);
         repeat (4) @(posedge ref_clk);
         wb(0, ADR_STAT, 0, 4'hF, q);
         chk_reg("fn_c", rows[i].fc, q[2:0]);
         chk_reg("fn_d", rows[i].fd, q[6:4]);
         cnt_rises();
         chk_reg("rise_c", er(rows[i].fc), rc);
         chk_reg("rise_d", er(rows[i].fd), rd);
         if (rows[i].fc < 3'h2) chk_pin("lvl_c", rows[i].fc[0], aux_out_c);
         if (rows[i].fd < 3'h2) chk_pin("lvl_d", rows[i].fd[0], aux_out_d);
      end
      $display("test table done");
      power_down_pin <= 1'b1;
      repeat (4) @(posedge ref_clk);
      cnt_rises();
      chk_reg("pd_rises", 0, rc + rd);
      chk_pin("pd_c", 1'b0, aux_out_c | aux_out_d);
      wb(0, ADR_STAT, 0, 4'hF, q); chk_pin("pd_stat", 1'b1, q[STAT_PD]);
      power_down_pin <= 1'b0;
      ref_input_select <= 1'b1;
      wb(1, ADR_CTRL, 32'h0000_0111, 4'hF, q);
      repeat (6) @(posedge ref_clk);
      cnt_rises();
      chk_reg("se_rises", 32'h0000_0008, rc);
      wb(0, ADR_STAT, 0, 4'hF, q); chk_pin("rsel", 1'b1, q[STAT_RSEL]);
      // Half a reference period apart: a running output would have flipped
      clk_en <= 1'b0;
      repeat (2) @(posedge ref_clk);
      rc = {30'h0, aux_out_d, aux_out_c};
      repeat (8) @(posedge ref_clk);
      chk_reg("frozen", rc, {30'h0, aux_out_d, aux_out_c});
      clk_en <= 1'b1;
      ref_input_select <= 1'b0;
      $display("test power and source done");
      wb(1, ADR_CTRL, 32'hFFFF_FFFF, 4'h1, q);
      wb(0, ADR_CTRL, 0, 4'hF, q); chk_reg("sel_mask", 32'h0000_0133, q);
      wb(1, 8'h10, 32'hFFFF_FFFF, 4'hF, q);
      wb(0, 8'h10, 0, 4'hF, q); chk_reg("unmapped", 0, q);
      wb(1, ADR_CTRL, 32'h0003_0000, 4'hF, q);
      repeat (8) @(posedge ref_clk);
      for (int k = 0; k < 4; k++) pulse_check(k, 1);
      wb(0, ADR_CNT, 0, 4'hF, q); chk_reg("cnt", 4, q);
      wb(0, ADR_POS, 0, 4'hF, q);
      chk_pin("pos_hit", 1'b1, |q[22:1]);
      chk_pin("pos_ends", 1'b1, q[0] & q[23]);
      wb(1, ADR_POS, 0, 4'hF, q);
      wb(0, ADR_POS, 0, 4'hF, q); chk_reg("pos_clr", 32'(POS_FIXED), q);
      c0 = n_capt;
      sr_per <= 1'b1;
      repeat (256) @(posedge ref_clk);
      sr_per <= 1'b0;
      repeat (40) @(posedge ref_clk);
      chk_reg("capt_per", 4, n_capt - c0);
      // Phase never reaches 15 with an 8-cycle reference
      wb(1, ADR_CTRL, 32'h000F_0000, 4'hF, q);
      pulse_check(0, 0);
      $display("test sysref done");
      rst_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      wb(0, ADR_CNT, 0, 4'hF, q); chk_reg("cnt_rst2", 0, q);
      wb(0, ADR_CTRL, 0, 4'hF, q); chk_reg("ctrl_rst2", CTRL_RST, q);
      $display("test second reset done");
      close_out();
   end
endmodule

//--- auxclk_sysref_win.sv
// Sysref position detector and capture at a selectable delay after the reference edge.
// Assumes sysref_s is already synchronised to ref_clk.
module auxclk_sysref_win
   import auxclk_pkg::*;
(
   input  wire logic             ref_clk,
   input  wire logic             rst_n,
   input  wire logic             clk_en,
   auxclk_ref_if.snk             refi,
   input  wire logic             sysref_s,
   input  wire logic [SEL_W-1:0] sel,
   input  wire logic             pos_clr,
   output logic      [NPOS-1:0]  pos_o,
   output logic                  capt_o
);

   logic [PH_W-1:0] phase_q;
   logic            prev_q;
   logic            samp_q;
   logic [NPOS-1:0] pos_q;
   logic            capt_q;
   wire  logic            at_pos;
   wire  logic            sr_rise;
   wire  logic [NPOS-1:0] hit;
   wire  logic [NPOS-1:0] pos_d;

   assign at_pos  = (phase_q == {1'b0, sel});
   assign sr_rise = sysref_s & ~prev_q;
   assign hit     = sr_rise ? (NPOS'(1) << phase_q) : '0;
   // Set wins over clear; end positions carry too little information
   assign pos_d   = (pos_clr ? '0 : pos_q) | hit | POS_FIXED;

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         phase_q <= '0;
         prev_q  <= 1'b0;
         samp_q  <= 1'b0;
         pos_q   <= POS_FIXED;
         capt_q  <= 1'b0;
      end
      else if (clk_en)
      begin
         prev_q <= sysref_s;
         pos_q  <= pos_d;
         if (refi.rise)
            phase_q <= '0;
         else if (phase_q < PH_W'(NPOS - 1))
            phase_q <= phase_q + PH_W'(1);
         // One sampling instant per reference cycle gives a fixed capture edge
         if (at_pos)
         begin
            samp_q <= sysref_s;
            capt_q <= sysref_s & ~samp_q;
         end
         else
            capt_q <= 1'b0;
      end
   end

   assign pos_o  = pos_q;
   assign capt_o = capt_q;

   // ==========================================================
   // Checks
   property p_capt_only_at_pos;
      @(posedge ref_clk) disable iff (!rst_n)
      (clk_en && !at_pos) |=> !capt_q;
   endproperty
   a_capt_only_at_pos: assert property (p_capt_only_at_pos) else $error("capture off position");

   property p_capt_on_edge;
      @(posedge ref_clk) disable iff (!rst_n)
      (clk_en && at_pos && sysref_s && !samp_q) |=> capt_q;
   endproperty
   a_capt_on_edge: assert property (p_capt_on_edge) else $error("sysref edge missed");

   property p_pos_ends;
      @(posedge ref_clk) disable iff (!rst_n)
      clk_en |=> (pos_q[0] && pos_q[NPOS-1]);
   endproperty
   a_pos_ends: assert property (p_pos_ends) else $error("end positions not flagged");

endmodule
